// ===== rtl/acsq_pkg.sv
// Purpose: Shared constants for the ADC conversion sequencer.
// Assumes: 100 MHz system clock; all times held in nanoseconds.
// Notes: Cycle counts are derived here so the logic never holds a bare figure.
package acsq_pkg;

  // ==========================================================
  // Clock
  localparam int CLK_MHZ = 100;

  // ==========================================================
  // Conversion timing
  localparam int T_CONV_NS = 1625;
  localparam int T_SYNC_NS = 4000;
  localparam int T_DRDY_PULSE_NS = 1000;
  // Per-conversion period for each rate code: 500, 250, 125, 62.5 kSPS
  localparam int T_PERIOD0_NS = 2000;
  localparam int T_PERIOD1_NS = 4000;
  localparam int T_PERIOD2_NS = 8000;
  localparam int T_PERIOD3_NS = 16000;

  // Least times round up, longest times round down
  localparam int CONV_CYC = (T_CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC = (T_SYNC_NS * CLK_MHZ) / 1000;
  localparam int DRDY_PULSE_CYC = (T_DRDY_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PERIOD0_CYC = (T_PERIOD0_NS * CLK_MHZ) / 1000;
  localparam int PERIOD1_CYC = (T_PERIOD1_NS * CLK_MHZ) / 1000;
  localparam int PERIOD2_CYC = (T_PERIOD2_NS * CLK_MHZ) / 1000;
  localparam int PERIOD3_CYC = (T_PERIOD3_NS * CLK_MHZ) / 1000;
  // Acquisition fills the fastest period; slower codes add nap in front
  localparam int ACQ_MIN_CYC = PERIOD0_CYC - CONV_CYC;

  // ==========================================================
  // Field widths and reset values
  localparam int CNT_W = 11;
  localparam int PULSE_W = 7;
  localparam int RESULT_W = 12;
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam logic [1:0] RATE_FASTEST = 2'h0;
  localparam logic MODE_SINGLE = 1'b0;
  localparam logic MODE_CONTINUOUS = 1'b1;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SYNC,
    ST_NAP,
    ST_ACQ,
    ST_CONV
  } acsq_state_t;

endpackage

// ===== rtl/acsq_result_mem.sv
// Purpose: Per-channel conversion result store.
// Assumes: One write and one read port on the system clock.
// Notes: Read data are registered; valid one cycle after the read strobe.
`timescale 1ns/1ps
module acsq_result_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Reset only the output so rd_data is defined before the first read; unwritten entries read back undefined
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // acsq_result_mem

// ===== rtl/acsq_sequencer.sv
// Purpose: Multichannel ADC conversion sequencer with host data-ready handshake.
// Assumes: Converter core presents its result on adc_result at the end of each conversion.
// Notes: Config bits arrive as write strobes with data; no register bus inside this block.
`timescale 1ns/1ps

// Contract
// - One mode bit selects single-pass or continuous conversion.
// - Single-pass converts each selected channel once per trigger, then idles.
// - Continuous mode repeats the selected channel sequence without further triggers.
// - Trigger, mode change, channel select or threshold rewrite aborts the running cycle.
// - Pin or internal start bit begins a fresh cycle over the selected channels.
// - Start bit written together with a mode change returns to wait-for-trigger.
// - Two-bit rate code gives 500, 250, 125 or 62.5 kSPS; reset 00.
// - Conversion 1.625 us; acquisition 0.375, 2.375, 6.375 or 14.375 us per code.
// - Per-channel rate is divided by the number of selected channels.
// - Rate code fixes continuous rate; in single-pass it caps, triggers set rate.
// - Any rate code other than 00 naps between conversions, both modes.
// - Single-pass: when all results are written, flag goes 1 and pin goes low.
// - Single-pass: result read or external pin restart clears flag, pin high.
// - Continuous: after each sequence, one 1 us low pulse on the data-ready pin.
// - Continuous: flag stays 0; only the pin pulse signals new data.
module acsq_sequencer
  import acsq_pkg::*;
#(
  parameter int NUM_CH = 16,
  parameter int CH_W = $clog2(NUM_CH),
  parameter int HALF_W = NUM_CH / 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // First configuration write
  input wire logic cfg0_wr,
  input wire logic conversion_mode_select,
  input wire logic internal_convert_start,
  // Second configuration write
  input wire logic cfg1_wr,
  input wire logic [1:0] sample_rate_select,
  // Channel select and threshold writes
  input wire logic chsel_lo_wr,
  input wire logic chsel_hi_wr,
  input wire logic [HALF_W-1:0] chsel_data,
  input wire logic threshold_wr,
  // External trigger pin, active low, asynchronous
  input wire logic external_convert_pin_n,
  // Converter core
  input wire logic [RESULT_W-1:0] adc_result,
  output logic [CH_W-1:0] adc_channel,
  output logic adc_sample,
  output logic adc_convert,
  output logic adc_nap,
  // Result read port
  input wire logic result_rd_en,
  input wire logic [CH_W-1:0] result_rd_addr,
  output logic [RESULT_W-1:0] result_rd_data,
  // Status
  output logic busy,
  output logic mode_status,
  output logic data_ready_flag,
  output logic data_ready_pin_n
);

  // ==========================================================
  // Helpers
  function automatic logic [CNT_W-1:0] period_cyc(input logic [1:0] rate);
    logic [CNT_W-1:0] p;
    p = CNT_W'(PERIOD0_CYC);
    case (rate)
      2'h1: p = CNT_W'(PERIOD1_CYC);
      2'h2: p = CNT_W'(PERIOD2_CYC);
      2'h3: p = CNT_W'(PERIOD3_CYC);
      default: p = CNT_W'(PERIOD0_CYC);
    endcase
    return p;
  endfunction

  // Lowest selected channel at or above start; MSB flags a find
  function automatic logic [CH_W:0] next_sel(input logic [NUM_CH-1:0] sel, input logic [CH_W:0] start);
    logic [CH_W:0] r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (sel[i] && (i >= int'(start))) begin
        r = {1'b1, CH_W'(i)};
      end
    end
    return r;
  endfunction

  // ==========================================================
  // State
  acsq_state_t state_reg, state_next;
  logic mode_reg;
  logic [1:0] rate_reg;
  logic [NUM_CH-1:0] sel_reg;
  logic [NUM_CH-1:0] run_sel_reg, run_sel_next;
  logic [CH_W-1:0] ch_reg, ch_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic flag_reg, flag_next;
  logic pin_n_reg, pin_n_next;
  logic [PULSE_W-1:0] pulse_reg, pulse_next;
  logic external_convert_pin_s1_reg, external_convert_pin_s2_reg, external_convert_pin_s3_reg;
  logic sample_reg, convert_reg, nap_reg, busy_reg;

  // ==========================================================
  // Event decode
  wire mode_change = cfg0_wr && (conversion_mode_select != mode_reg);
  wire internal_convert_start_trig = cfg0_wr && internal_convert_start && !mode_change;
  wire ext_trig = external_convert_pin_s3_reg && !external_convert_pin_s2_reg;
  wire trigger = internal_convert_start_trig || ext_trig;
  wire abort = mode_change || chsel_lo_wr || chsel_hi_wr || threshold_wr;
  wire cnt_zero = (cnt_reg == '0);
  wire conv_done = (state_reg == ST_CONV) && cnt_zero;
  // Aborted or restarted conversions leave no result and raise no ready
  wire conv_keep = conv_done && !trigger && !abort;
  wire [CH_W:0] first_hit = next_sel(sel_reg, '0);
  wire [CH_W:0] after_hit = next_sel(run_sel_reg, {1'b0, ch_reg} + 1'b1);
  wire [CH_W:0] wrap_hit = next_sel(run_sel_reg, '0);
  wire pass_done = conv_keep && !after_hit[CH_W];
  wire rate_naps = (rate_reg != RATE_FASTEST);
  wire [CNT_W-1:0] nap_len = period_cyc(rate_reg) - CNT_W'(PERIOD0_CYC);
  wire [CNT_W-1:0] slot_cnt = rate_naps ? nap_len - 1'b1 : CNT_W'(ACQ_MIN_CYC - 1);
  wire acsq_state_t slot_state = rate_naps ? ST_NAP : ST_ACQ;

  // ==========================================================
  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
    ch_next = ch_reg;
    run_sel_next = run_sel_reg;
    if (trigger) begin
      state_next = ST_SYNC;
      cnt_next = CNT_W'(SYNC_CYC - 1);
    end else if (abort) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_IDLE;
        end
        ST_SYNC: begin
          if (cnt_zero) begin
            run_sel_next = sel_reg;
            if (first_hit[CH_W]) begin
              ch_next = first_hit[CH_W-1:0];
              state_next = slot_state;
              cnt_next = slot_cnt;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_NAP: begin
          if (cnt_zero) begin
            state_next = ST_ACQ;
            cnt_next = CNT_W'(ACQ_MIN_CYC - 1);
          end
        end
        ST_ACQ: begin
          if (cnt_zero) begin
            state_next = ST_CONV;
            cnt_next = CNT_W'(CONV_CYC - 1);
          end
        end
        ST_CONV: begin
          if (cnt_zero) begin
            if (after_hit[CH_W]) begin
              ch_next = after_hit[CH_W-1:0];
              state_next = slot_state;
              cnt_next = slot_cnt;
            end else if (mode_reg == MODE_CONTINUOUS) begin
              ch_next = wrap_hit[CH_W-1:0];
              state_next = slot_state;
              cnt_next = slot_cnt;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Data-ready handshake
  wire single_mode = (mode_reg == MODE_SINGLE);
  wire flag_set = pass_done && single_mode;
  wire flag_clr = result_rd_en || ext_trig;
  wire pulse_start = pass_done && !single_mode;
  wire to_cont = cfg0_wr && (conversion_mode_select == MODE_CONTINUOUS);

  always_comb begin
    flag_next = flag_reg;
    pulse_next = (pulse_reg == '0) ? pulse_reg : pulse_reg - 1'b1;
    // Cleared on the switching edge, so continuous never shows a stale flag
    if (!single_mode || to_cont) begin
      flag_next = 1'b0;
    end else if (flag_set) begin
      flag_next = 1'b1;
    end else if (flag_clr) begin
      flag_next = 1'b0;
    end
    if (pulse_start) begin
      pulse_next = PULSE_W'(DRDY_PULSE_CYC);
    end
    if (single_mode) begin
      pulse_next = '0;
    end
    pin_n_next = single_mode ? !flag_next : (pulse_next == '0);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= MODE_SINGLE;
      rate_reg <= RATE_RESET;
      sel_reg <= '0;
    end else begin
      if (cfg0_wr) begin
        mode_reg <= conversion_mode_select;
      end
      if (cfg1_wr) begin
        rate_reg <= sample_rate_select;
      end
      if (chsel_lo_wr) begin
        sel_reg[HALF_W-1:0] <= chsel_data;
      end
      if (chsel_hi_wr) begin
        sel_reg[NUM_CH-1:HALF_W] <= chsel_data;
      end
    end
  end

  // Pin is idle high, so every stage resets to 1
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      external_convert_pin_s1_reg <= 1'b1;
      external_convert_pin_s2_reg <= 1'b1;
      external_convert_pin_s3_reg <= 1'b1;
    end else begin
      external_convert_pin_s1_reg <= external_convert_pin_n;
      external_convert_pin_s2_reg <= external_convert_pin_s1_reg;
      external_convert_pin_s3_reg <= external_convert_pin_s2_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      ch_reg <= '0;
      run_sel_reg <= '0;
      flag_reg <= 1'b0;
      pin_n_reg <= 1'b1;
      pulse_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ch_reg <= ch_next;
      run_sel_reg <= run_sel_next;
      flag_reg <= flag_next;
      pin_n_reg <= pin_n_next;
      pulse_reg <= pulse_next;
    end
  end

  // Outputs follow the next state so they stay aligned with it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sample_reg <= 1'b0;
      convert_reg <= 1'b0;
      nap_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      sample_reg <= (state_next == ST_ACQ);
      convert_reg <= (state_next == ST_CONV);
      nap_reg <= (state_next == ST_NAP);
      busy_reg <= (state_next != ST_IDLE);
    end
  end

  // ==========================================================
  // Result store
  acsq_result_mem #(
    .WIDTH(RESULT_W),
    .DEPTH(NUM_CH),
    .AW(CH_W)
  ) u_result_mem (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wr_en(conv_keep),
    .wr_addr(ch_reg),
    .wr_data(adc_result),
    .rd_en(result_rd_en),
    .rd_addr(result_rd_addr),
    .rd_data(result_rd_data)
  );

  assign adc_channel = ch_reg;
  assign adc_sample = sample_reg;
  assign adc_convert = convert_reg;
  assign adc_nap = nap_reg;
  assign busy = busy_reg;
  assign mode_status = mode_reg;
  assign data_ready_flag = flag_reg;
  assign data_ready_pin_n = pin_n_reg;

endmodule // acsq_sequencer

// ===== verification/acsq_sequencer_asserts.sv
// Purpose: Port-level timing and handshake checks for the sequencer.
// Assumes: Cycle constants of the package match the sequencer build.
// Notes: Aborted phases are skipped by asking that the next phase follows.
`timescale 1ns/1ps
module acsq_sequencer_asserts
  import acsq_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Writes
  input wire logic cfg0_wr,
  input wire logic conversion_mode_select,
  input wire logic cfg1_wr,
  input wire logic [1:0] sample_rate_select,
  input wire logic chsel_lo_wr,
  input wire logic chsel_hi_wr,
  input wire logic threshold_wr,
  input wire logic result_rd_en,
  // Watched outputs
  input wire logic adc_sample,
  input wire logic adc_convert,
  input wire logic adc_nap,
  input wire logic busy,
  input wire logic mode_status,
  input wire logic data_ready_flag,
  input wire logic data_ready_pin_n
);
  int acq_reg, conv_reg, nap_reg, low_reg, nap_cyc;
  logic [1:0] rate_reg;
  assign nap_cyc = (rate_reg == 2'h0) ? 0 : (rate_reg == 2'h1) ? PERIOD1_CYC - PERIOD0_CYC :
    (rate_reg == 2'h2) ? PERIOD2_CYC - PERIOD0_CYC : PERIOD3_CYC - PERIOD0_CYC;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acq_reg <= 0;
      conv_reg <= 0;
      nap_reg <= 0;
      low_reg <= 0;
      rate_reg <= RATE_RESET;
    end else begin
      acq_reg <= adc_sample ? acq_reg + 1 : 0;
      conv_reg <= adc_convert ? conv_reg + 1 : 0;
      nap_reg <= adc_nap ? nap_reg + 1 : 0;
      low_reg <= data_ready_pin_n ? 0 : low_reg + 1;
      rate_reg <= cfg1_wr ? sample_rate_select : rate_reg;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Phases
  acq_len_a: assert property ($rose(adc_convert) |-> acq_reg == ACQ_MIN_CYC)
    else $error("acquisition length wrong");
  conv_len_a: assert property ($fell(adc_convert) && (adc_sample || adc_nap) |-> conv_reg == CONV_CYC)
    else $error("conversion length wrong");
  nap_len_a: assert property ($fell(adc_nap) && adc_sample |-> nap_reg == nap_cyc)
    else $error("nap length wrong");
  nap_rate_a: assert property (adc_nap |-> rate_reg != RATE_FASTEST)
    else $error("nap at fastest rate");
  sync_wait_a: assert property ($rose(busy) |-> ##[1:401] (adc_sample || adc_nap || !busy))
    else $error("start delay too long");
  // ==========================================================
  // Aborts and handshake
  abort_idle_a: assert property ((threshold_wr || chsel_lo_wr || chsel_hi_wr) && !cfg0_wr |=> !busy)
    else $error("rewrite did not abort");
  mode_idle_a: assert property (cfg0_wr && conversion_mode_select != mode_status
    |=> !busy && mode_status == $past(conversion_mode_select)) else $error("mode change not idle");
  single_hs_a: assert property (!mode_status && $past(!mode_status) |-> data_ready_flag == !data_ready_pin_n)
    else $error("flag and pin disagree");
  read_clear_a: assert property (result_rd_en && !mode_status && !busy && !cfg0_wr
    |=> !data_ready_flag && data_ready_pin_n) else $error("read did not clear ready");
  cont_flag_a: assert property (mode_status |-> !data_ready_flag)
    else $error("flag set in continuous mode");
  pulse_len_a: assert property ($rose(data_ready_pin_n) && mode_status && $past(mode_status)
    |-> low_reg == DRDY_PULSE_CYC) else $error("ready pulse length wrong");
  cover property ($rose(data_ready_flag));
  cover property ($fell(data_ready_pin_n) && mode_status);
  cover property ($rose(adc_nap));
endmodule // acsq_sequencer_asserts

bind acsq_sequencer acsq_sequencer_asserts u_asserts (.clk_sys, .resetn, .cfg0_wr, .conversion_mode_select,
  .cfg1_wr, .sample_rate_select, .chsel_lo_wr, .chsel_hi_wr, .threshold_wr, .result_rd_en, .adc_sample,
  .adc_convert, .adc_nap, .busy, .mode_status, .data_ready_flag, .data_ready_pin_n);

// ===== verification/acsq_adc_model.sv
// Purpose: Converter core stand-in beside the sequencer.
// Assumes: Result is taken on the last conversion cycle.
// Notes: Result carries its channel so a misfiled write shows.
`timescale 1ns/1ps
module acsq_adc_model
  import acsq_pkg::*;
(
  // Sequencer side
  input wire logic [3:0] adc_channel,
  input wire logic adc_convert,
  output logic [RESULT_W-1:0] adc_result
);
  // Inverted outside conversion so a late sample is caught
  assign adc_result = adc_convert ? {adc_channel, 8'h3c} : {~adc_channel, 8'hc3};
endmodule // acsq_adc_model

// ===== verification/adc_conversion_sequencer_tb_top.sv
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Converter model answers with a channel-coded result.
// Notes: Reads are checked by a monitor against a queue of expected results.
`timescale 1ns/1ps
module adc_conversion_sequencer_tb_top;
  import acsq_pkg::*;
  logic clk_sys = 1'h0, resetn = 1'h0, cfg0_wr = 1'h0, conversion_mode_select = 1'h0, internal_convert_start = 1'h0;
  logic cfg1_wr = 1'h0, chsel_lo_wr = 1'h0, chsel_hi_wr = 1'h0, threshold_wr = 1'h0, result_rd_en = 1'h0;
  logic external_convert_pin_n = 1'h1, rd_v = 1'h0;
  logic [1:0] sample_rate_select = 2'h0;
  logic [7:0] chsel_data = 8'h00;
  logic [3:0] result_rd_addr = 4'h0, adc_channel;
  logic [11:0] adc_result, result_rd_data;
  logic adc_sample, adc_convert, adc_nap, busy, mode_status, data_ready_flag, data_ready_pin_n;
  logic [31:0] rnd = 32'h810701e0;
  logic [15:0] sel;
  logic [11:0] exp_q[$];
  int miscompares = 0, n_tests = 0, cyc = 0, t0, i;

  acsq_sequencer DUT (.clk_sys, .resetn, .cfg0_wr, .conversion_mode_select, .internal_convert_start, .cfg1_wr,
    .sample_rate_select, .chsel_lo_wr, .chsel_hi_wr, .chsel_data, .threshold_wr, .external_convert_pin_n, .adc_result,
    .adc_channel, .adc_sample, .adc_convert, .adc_nap, .result_rd_en, .result_rd_addr, .result_rd_data, .busy,
    .mode_status, .data_ready_flag, .data_ready_pin_n);
  acsq_adc_model u_adc (.adc_channel, .adc_convert, .adc_result);

  always #5 clk_sys = ~clk_sys;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic pulse0(input logic m, input logic s);
    @(negedge clk_sys);
    conversion_mode_select = m;
    internal_convert_start = s;
    cfg0_wr = 1'h1;
    @(negedge clk_sys);
    cfg0_wr = 1'h0;
    internal_convert_start = ~s;
  endtask
  task automatic wr_sel(input logic [15:0] m);
    @(negedge clk_sys);
    chsel_data = m[7:0];
    chsel_lo_wr = 1'h1;
    @(negedge clk_sys);
    chsel_lo_wr = 1'h0;
    chsel_data = m[15:8];
    chsel_hi_wr = 1'h1;
    @(negedge clk_sys);
    chsel_hi_wr = 1'h0;
    chsel_data = ~m[15:8];
  endtask
  task automatic wr_rate(input logic [1:0] r);
    @(negedge clk_sys);
    sample_rate_select = r;
    cfg1_wr = 1'h1;
    @(negedge clk_sys);
    cfg1_wr = 1'h0;
    sample_rate_select = ~r;
  endtask
  // Bounded wait on busy (0) or the ready pin (1)
  task automatic wait_for(input int which, input logic v, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(negedge clk_sys);
      if ((which ? data_ready_pin_n : busy) === v) return;
    end
    check(16'h1, 16'h0);
  endtask
  task automatic rd(input logic [3:0] a);
    exp_q.push_back({a, 8'h3c});
    @(negedge clk_sys);
    result_rd_addr = a;
    result_rd_en = 1'h1;
    @(negedge clk_sys);
    result_rd_en = 1'h0;
    result_rd_addr = ~a;
  endtask

  // ==========================================================
  // Read monitor and watchdog
  always @(posedge clk_sys) begin
    if (rd_v) check(16'(result_rd_data), 16'(exp_q.pop_front()));
    rd_v <= result_rd_en;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (20) @(negedge clk_sys);
    resetn = 1'h1;
    @(negedge clk_sys);
    check(data_ready_pin_n, 1'h1);
    rnd = xs(rnd);
    sel = rnd[15:0] | 16'h0001;
    wr_sel(sel);
    pulse0(1'h0, 1'h1);
    wait_for(0, 1'h0, 4000);
    check(data_ready_flag, 1'h1);
    check(data_ready_pin_n, 1'h0);
    repeat (300) @(negedge clk_sys);
    check(busy, 1'h0);
    for (i = 0; i < 16; i++) if (sel[i]) rd(4'(i));
    check(data_ready_flag, 1'h0);
    // Pin restarts with nap between conversions
    wr_rate(2'h1);
    for (i = 0; i < 2; i++) begin
      @(negedge clk_sys);
      external_convert_pin_n = 1'h0;
      repeat (4) @(negedge clk_sys);
      external_convert_pin_n = 1'h1;
      repeat (4) @(negedge clk_sys);
      check(busy, 1'h1);
      check(data_ready_flag, 1'h0);
      wait_for(0, 1'h0, 8000);
    end
    // Flag is still set here; switching to continuous must drop it at once
    pulse0(1'h1, 1'h0);
    check(data_ready_flag, 1'h0);
    check(data_ready_pin_n, 1'h1);
    pulse0(1'h0, 1'h0);
    rd(4'h0);
    // Abort by threshold, then by channel rewrite
    for (i = 0; i < 2; i++) begin
      pulse0(1'h0, 1'h1);
      repeat (450) @(negedge clk_sys);
      if (i) wr_sel(sel);
      else begin
        threshold_wr = 1'h1;
        @(negedge clk_sys);
        threshold_wr = 1'h0;
      end
      @(negedge clk_sys);
      check(busy, 1'h0);
    end
    // Start together with a mode change must not run
    pulse0(1'h1, 1'h1);
    @(negedge clk_sys);
    check(busy, 1'h0);
    check(mode_status, 1'h1);
    // Continuous at every rate code, first and last channel
    wr_sel(16'h8001);
    for (i = 0; i < 4; i++) begin
      pulse0(1'h0, 1'h0);
      wr_rate(2'(i));
      pulse0(1'h1, 1'h0);
      pulse0(1'h1, 1'h1);
      wait_for(1, 1'h0, 8000);
      t0 = cyc;
      wait_for(1, 1'h1, 200);
      check(16'(cyc - t0), 16'(DRDY_PULSE_CYC));
      wait_for(1, 1'h0, 8000);
      check(16'(cyc - t0), 16'(2 * (PERIOD0_CYC << i)));
      check(data_ready_flag, 1'h0);
      check(busy, 1'h1);
    end
    pulse0(1'h0, 1'h0);
    @(negedge clk_sys);
    check(busy, 1'h0);
    print_verdict();
  end
endmodule // adc_conversion_sequencer_tb_top
